// >>> design/spdf_defines.svh
// constants of the science packet data field formatter
`ifndef SPDF_DEFINES_SVH
`define SPDF_DEFINES_SVH

// ----------------------------------------------------------------
// field geometry (bit positions are packet bit numbers)
// ----------------------------------------------------------------
`define SPDF_WORD_BITS 5'h0C
`define SPDF_FIELD_BITS 13'h1374
`define SPDF_FIELD_START 13'h0090
`define SPDF_DAY_WORDS 9'h19F
`define SPDF_NIGHT_WORDS 9'h0AB
`define SPDF_NIGHT_DATA_WORDS 9'h0AA
`define SPDF_DAY_SAMPLE2_START 13'h0474
`define SPDF_DAY_SAMPLE3_START 13'h0858

// ----------------------------------------------------------------
// second engineering group layout
// ----------------------------------------------------------------
`define SPDF_E2P1_HK_START 13'h0090
`define SPDF_E2P1_ANC_START 13'h0490
`define SPDF_E2P1_CMD_START 13'h0890
`define SPDF_E2P1_FILL_START 13'h09D0
`define SPDF_E2P2_GAIN_START 13'h0090
`define SPDF_E2P2_FILL_START 13'h11C0

// ----------------------------------------------------------------
// header values
// ----------------------------------------------------------------
`define SPDF_APID_NORMAL 7'h40
`define SPDF_APID_TEST 7'h7F
`define SPDF_TYPE_DAY 3'h1
`define SPDF_TYPE_NIGHT 3'h2
`define SPDF_TYPE_ENG1 3'h3
`define SPDF_TYPE_ENG2 3'h4
`define SPDF_SEQ_RESET 14'h0000

`endif

// >>> design/spdf_formatter.sv
// science packet data field formatter: streams 12-bit field words
`timescale 1ns/100ps
`include "spdf_defines.svh"

module spdf_formatter (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic FRAME_START,
  input wire spdf_pkg::spdf_kind_t FRAME_KIND,
  input wire logic TEST_CMD_STB,
  input wire logic TEST_CMD_TEST,
  input wire logic [11:0] IN_DATA,
  input wire logic IN_VALID,
  input wire logic IN_GROUP_END,
  input wire logic IN_LAST,
  output logic IN_READY,
  output logic [11:0] OUT_DATA,
  output logic OUT_VALID,
  output logic OUT_FIRST,
  output logic OUT_LAST,
  input wire logic OUT_READY,
  output logic PKT_START,
  output logic [6:0] HDR_APID,
  output logic [13:0] HDR_SEQ,
  output logic [2:0] HDR_PKT_TYPE,
  output logic HDR_SRC_ZERO,
  output logic MSG_CTRL_RR,
  output logic TEST_ACTIVE,
  output logic BUSY
);
  import spdf_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // top 12 of the n valid low bits of the packer
  function automatic logic [11:0] take_top(input logic [18:0] a,
                                           input logic [4:0] n);
    logic [18:0] s;
    s = a >> (5'(n - `SPDF_WORD_BITS));
    return s[11:0];
  endfunction

  // partial word left-aligned, zeros below
  function automatic logic [11:0] flush_word(input logic [18:0] a,
                                             input logic [4:0] n);
    logic [18:0] s;
    s = a << (5'(`SPDF_WORD_BITS - n));
    return s[11:0];
  endfunction

  spdf_state_t r;
  spdf_state_t n;

  logic pop;
  logic room;
  logic emit;
  logic [11:0] word;
  logic [8:0] nwords;
  logic [8:0] ndata;
  logic [12:0] limit;
  logic eng;
  logic last_word;
  logic start_pkt;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    emit = 1'b0;
    word = 12'h000;
    start_pkt = 1'b0;
    n.pkt_start = 1'b0;
    eng = (r.kind == SPDF_ENG1) || (r.kind == SPDF_ENG2);
    // night is the short form; day and engineering are the long form
    nwords = (r.kind == SPDF_NIGHT) ? `SPDF_NIGHT_WORDS
                                    : `SPDF_DAY_WORDS;
    ndata = (r.kind == SPDF_NIGHT) ? `SPDF_NIGHT_DATA_WORDS
                                   : `SPDF_DAY_WORDS;
    case (r.kind)
      SPDF_ENG2: begin
        if (r.pkt2) begin
          limit = 13'(`SPDF_E2P2_FILL_START - `SPDF_E2P2_GAIN_START);
        end else begin
          limit = 13'(`SPDF_E2P1_FILL_START - `SPDF_E2P1_HK_START);
        end
      end
      default: limit = `SPDF_FIELD_BITS;
    endcase

    // command latch; a frame in flight keeps the mode it started with
    if (TEST_CMD_STB) begin
      n.cmd_test = TEST_CMD_TEST;
    end

    // output buffer pop
    pop = r.b0v && OUT_READY;
    if (pop) begin
      n.b0v = r.b1v;
      n.b0d = r.b1d;
      n.b0f = r.b1f;
      n.b0l = r.b1l;
      n.b1v = 1'b0;
    end
    // receiver stall holds the engine here, no word is lost
    room = !(r.b0v && r.b1v) || pop;
    last_word = (r.idx == 9'(nwords - 9'h001));

    case (r.st)
      SPDF_IDLE: begin
        if (FRAME_START) begin
          n.kind = FRAME_KIND;
          n.test = r.cmd_test;
          n.pkt2 = 1'b0;
          start_pkt = 1'b1;
        end
      end
      SPDF_NEXT: begin
        n.pkt2 = 1'b1;
        start_pkt = 1'b1;
      end
      SPDF_RUN: begin
        if (room) begin
          if (r.test) begin
            // fixed count 1..415 for day and engineering, 1..170 then one zero word for night
            if (r.idx < ndata) begin
              word = 12'(r.idx + 9'h001);
            end else begin
              word = 12'h000;
            end
            emit = 1'b1;
          end else if (!eng) begin
            if (r.idx >= ndata) begin
              word = 12'h000;
              emit = 1'b1;
            end else if (r.hold_v) begin
              // words pass in delivered order, blocks back to back
              word = r.hold_d;
              n.hold_v = 1'b0;
              emit = 1'b1;
            end
          end else begin
            if (r.acc_n >= `SPDF_WORD_BITS) begin
              word = take_top(r.acc, r.acc_n);
              n.acc_n = 5'(r.acc_n - `SPDF_WORD_BITS);
              emit = 1'b1;
            end else if (r.pad && r.acc_n == 5'h00) begin
              n.pad = 1'b0;
            end else if (r.pad || r.done || r.cons >= limit) begin
              // partial group word or trailing fill, zero padded
              word = flush_word(r.acc, r.acc_n);
              n.acc_n = 5'h00;
              n.pad = 1'b0;
              emit = 1'b1;
            end else if (r.hold_v) begin
              n.acc = {r.acc[10:0], r.hold_d[7:0]};
              n.acc_n = 5'(r.acc_n + 5'h08);
              n.cons = 13'(r.cons + 13'h0008);
              n.pad = r.hold_g;
              n.done = r.hold_l;
              n.hold_v = 1'b0;
            end
          end
        end
        if (emit) begin
          n.idx = 9'(r.idx + 9'h001);
          if (last_word) begin
            if (r.kind != SPDF_NIGHT && !r.pkt2) begin
              n.st = SPDF_NEXT;
            end else begin
              n.st = SPDF_IDLE;
            end
          end
        end
      end
      default: n.st = SPDF_IDLE;
    endcase

    if (start_pkt) begin
      n.st = SPDF_RUN;
      n.idx = 9'h000;
      n.acc = 19'h00000;
      n.acc_n = 5'h00;
      n.cons = 13'h0000;
      n.pad = 1'b0;
      n.done = 1'b0;
      n.pkt_start = 1'b1;
      if (n.test) begin
        n.apid = `SPDF_APID_TEST;
        n.seq = r.seq_test;
        n.seq_test = 14'(r.seq_test + 14'h0001);
      end else begin
        n.apid = `SPDF_APID_NORMAL;
        n.seq = r.seq_norm;
        n.seq_norm = 14'(r.seq_norm + 14'h0001);
      end
      case (n.kind)
        SPDF_DAY: n.ptype = `SPDF_TYPE_DAY;
        SPDF_NIGHT: n.ptype = `SPDF_TYPE_NIGHT;
        SPDF_ENG1: n.ptype = `SPDF_TYPE_ENG1;
        default: n.ptype = `SPDF_TYPE_ENG2;
      endcase
      n.src_zero = (n.kind == SPDF_ENG1) || (n.kind == SPDF_ENG2);
      n.msg_rr = n.test;
    end

    // push into the two-entry buffer
    if (emit) begin
      if (!n.b0v) begin
        n.b0v = 1'b1;
        n.b0d = word;
        n.b0f = (r.idx == 9'h000);
        n.b0l = last_word;
      end else begin
        n.b1v = 1'b1;
        n.b1d = word;
        n.b1f = (r.idx == 9'h000);
        n.b1l = last_word;
      end
    end

    // single-word input holding stage, ready straight from a flop
    if (IN_VALID && r.in_rdy) begin
      n.hold_v = 1'b1;
      n.hold_d = IN_DATA;
      n.hold_g = IN_GROUP_END;
      n.hold_l = IN_LAST;
    end
    n.in_rdy = !n.hold_v;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      r <= '0;
      r.st <= SPDF_IDLE;
      r.kind <= SPDF_DAY;
      r.seq_norm <= `SPDF_SEQ_RESET;
      r.seq_test <= `SPDF_SEQ_RESET;
      r.apid <= `SPDF_APID_NORMAL;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------
  assign IN_READY = r.in_rdy;
  assign OUT_DATA = r.b0d;
  assign OUT_VALID = r.b0v;
  assign OUT_FIRST = r.b0f;
  assign OUT_LAST = r.b0l;
  assign PKT_START = r.pkt_start;
  assign HDR_APID = r.apid;
  assign HDR_SEQ = r.seq;
  assign HDR_PKT_TYPE = r.ptype;
  assign HDR_SRC_ZERO = r.src_zero;
  assign MSG_CTRL_RR = r.msg_rr;
  assign TEST_ACTIVE = r.test;
  assign BUSY = (r.st != SPDF_IDLE);

endmodule

// >>> design/spdf_pkg.sv
// types of the science packet data field formatter
package spdf_pkg;

  typedef enum logic [1:0] {
    SPDF_IDLE = 2'b00,
    SPDF_RUN = 2'b01,
    SPDF_NEXT = 2'b10
  } spdf_fsm_t;

  typedef enum logic [1:0] {
    SPDF_DAY = 2'b00,
    SPDF_NIGHT = 2'b01,
    SPDF_ENG1 = 2'b10,
    SPDF_ENG2 = 2'b11
  } spdf_kind_t;

  typedef struct packed {
    spdf_fsm_t st;
    spdf_kind_t kind;
    logic test;
    logic pkt2;
    logic [8:0] idx;
    logic [18:0] acc;
    logic [4:0] acc_n;
    logic [12:0] cons;
    logic pad;
    logic done;
    logic hold_v;
    logic [11:0] hold_d;
    logic hold_g;
    logic hold_l;
    logic in_rdy;
    logic b0v;
    logic [11:0] b0d;
    logic b0f;
    logic b0l;
    logic b1v;
    logic [11:0] b1d;
    logic b1f;
    logic b1l;
    logic cmd_test;
    logic [13:0] seq_norm;
    logic [13:0] seq_test;
    logic [6:0] apid;
    logic [13:0] seq;
    logic [2:0] ptype;
    logic src_zero;
    logic msg_rr;
    logic pkt_start;
  } spdf_state_t;

endpackage

// >>> verification/spdf_formatter_props.sv
// port assertions of the science packet data field formatter
`timescale 1ns/100ps
module spdf_formatter_props (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic FRAME_START,
  input wire spdf_pkg::spdf_kind_t FRAME_KIND,
  input wire logic OUT_VALID,
  input wire logic [11:0] OUT_DATA,
  input wire logic OUT_FIRST,
  input wire logic OUT_LAST,
  input wire logic OUT_READY,
  input wire logic PKT_START,
  input wire logic [6:0] HDR_APID,
  input wire logic [2:0] HDR_PKT_TYPE,
  input wire logic HDR_SRC_ZERO,
  input wire logic MSG_CTRL_RR,
  input wire logic TEST_ACTIVE,
  input wire logic BUSY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  sequence s_go;
    FRAME_START && !BUSY;
  endsequence
  sequence s_test_go;
    s_go ##1 TEST_ACTIVE;
  endsequence
  property p_go;
    s_go |=> PKT_START && BUSY;
  endproperty
  a_go: assert property (p_go) else $error("frame not started");
  property p_kind;
    s_go |=> HDR_PKT_TYPE == {1'b0, $past(FRAME_KIND)} + 3'h1;
  endproperty
  a_kind: assert property (p_kind) else $error("wrong type code");
  property p_apid;
    PKT_START |-> HDR_APID == (TEST_ACTIVE ? 7'h7F : 7'h40);
  endproperty
  a_apid: assert property (p_apid) else $error("wrong identifier");
  property p_rr;
    PKT_START |-> MSG_CTRL_RR == TEST_ACTIVE;
  endproperty
  a_rr: assert property (p_rr) else $error("wrong symbol");
  property p_src;
    PKT_START |-> HDR_SRC_ZERO == (HDR_PKT_TYPE > 3'h2);
  endproperty
  a_src: assert property (p_src) else $error("source not zeroed");
  property p_tfirst;
    s_test_go |=> OUT_VALID && OUT_FIRST && OUT_DATA == 12'h001;
  endproperty
  a_tfirst: assert property (p_tfirst) else $error("bad first");
  property p_tmax;
    TEST_ACTIVE && OUT_VALID |-> OUT_DATA <= 12'h19F;
  endproperty
  a_tmax: assert property (p_tmax) else $error("count too high");
  property p_stall;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA)
      && $stable(OUT_FIRST) && $stable(OUT_LAST);
  endproperty
  a_stall: assert property (p_stall) else $error("word lost");
endmodule

// >>> verification/spdf_formatter_tb.sv
// testbench of the science packet data field formatter
`timescale 1ns/100ps
`include "spdf_defines.svh"
module spdf_formatter_tb;
  import spdf_pkg::*;
  logic MCLK = 0, RSTN = 0, FRAME_START = 0, TEST_CMD_STB = 0;
  logic TEST_CMD_TEST = 0, IN_VALID = 0, IN_LAST = 0, stall = 0;
  logic IN_GROUP_END = 0;
  spdf_kind_t FRAME_KIND = SPDF_DAY;
  logic [11:0] IN_DATA = 12'h000, OUT_DATA;
  logic IN_READY, OUT_VALID, OUT_FIRST, OUT_LAST, OUT_READY, PKT_START;
  logic BUSY, HDR_SRC_ZERO, MSG_CTRL_RR, TEST_ACTIVE;
  logic [6:0] HDR_APID;
  logic [13:0] HDR_SEQ;
  logic [2:0] HDR_PKT_TYPE;
  logic [12:0] tot;
  int n_errors = 0, comparisons = 0;
  int sq [2] = '{0, 0};
  always #25 MCLK = ~MCLK;
  spdf_formatter u_dut (.MCLK, .RSTN, .FRAME_START, .FRAME_KIND,
    .TEST_CMD_STB, .TEST_CMD_TEST, .IN_DATA, .IN_VALID,
    .IN_GROUP_END, .IN_LAST, .IN_READY, .OUT_DATA, .OUT_VALID,
    .OUT_FIRST, .OUT_LAST, .OUT_READY, .PKT_START, .HDR_APID, .HDR_SEQ,
    .HDR_PKT_TYPE, .HDR_SRC_ZERO, .MSG_CTRL_RR, .TEST_ACTIVE, .BUSY);
  spdf_sink u_sink (.clk(MCLK), .rstn(RSTN), .valid(OUT_VALID),
    .data(OUT_DATA), .first(OUT_FIRST), .last(OUT_LAST), .stall,
    .ready(OUT_READY), .tot);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(logic t);
    @(negedge MCLK);
    TEST_CMD_STB = 1;
    TEST_CMD_TEST = t;
    @(negedge MCLK);
    TEST_CMD_STB = 0;
  endtask
  // engineering bytes packed msb first, zero past the last byte
  function automatic logic [11:0] eword(int o, int nb, int j);
    logic [11:0] w;
    int p;
    for (int b = 0; b < 12; b++) begin
      p = 12 * j + b;
      w[11 - b] = p < 8 * nb ? 1'(((o + p / 8) >> (7 - p % 8)) & 1) : 1'b0;
    end
    return w;
  endfunction
  // m: 0 normal science, 1 test, 2 normal second engineering group,
  // 3 normal first engineering group with group ends
  task automatic frame(spdf_kind_t k, int n, int w, int m);
    int base, i, c, len, kk, e;
    logic rdy, t;
    logic [6:0] ap;
    logic [13:0] s, x;
    base = tot;
    i = 0;
    rdy = 0;
    t = m == 1;
    len = k == SPDF_NIGHT ? 171 : 415;
    ap = t ? `SPDF_APID_TEST : `SPDF_APID_NORMAL;
    @(negedge MCLK);
    FRAME_KIND = k;
    FRAME_START = 1;
    for (c = 0; c < 20000 && tot - base < w; c++) begin
      @(negedge MCLK);
      FRAME_START = 0;
      if (IN_VALID && rdy) i++;
      rdy = IN_READY;
      IN_VALID = i < n;
      IN_DATA = i[11:0];
      IN_LAST = m > 1 && (i == (m == 2 ? 295 : 3) || i == n - 1);
      IN_GROUP_END = m == 3 && (i == 1 || i == 5);
      if (PKT_START) begin
        check("type", HDR_PKT_TYPE, {1'b0, k} + 3'h1);
        check("apid", HDR_APID, ap);
        check("rr", MSG_CTRL_RR, t);
        check("src", HDR_SRC_ZERO, k[1]);
        check("seq", HDR_SEQ, 16'(sq[t]));
        sq[t]++;
      end
    end
    if (c == 20000) begin
      n_errors++;
      finish_test();
    end
    repeat (6) @(negedge MCLK);
    check("count", 16'(tot - base), 16'(w));
    check("busy", BUSY, 1'b0);
    for (int j = 0; j < w; j++) begin
      kk = j % len;
      case (m)
        0: e = (kk < 170 || len > 171) ? j : 0;
        1: e = (kk < 170 || len > 171) ? kk + 1 : 0;
        2: e = eword(j < 415 ? 0 : 296, j < 415 ? 296 : 550, kk);
        // two groups of two bytes per packet, each group end pads
        default: e = kk > 3 ? 0 : (4 * (j / 415) + kk) << (kk % 2 ? 8 : 4);
      endcase
      x = {kk == 0, kk == len - 1, e[11:0]};
      s = u_sink.mem[base + j];
      check("word", s, x);
    end
  endtask
  task automatic t_day();
    frame(SPDF_DAY, 830, 830, 0);
    $display("day frame done");
  endtask
  task automatic t_night();
    frame(SPDF_NIGHT, 170, 171, 0);
    $display("night frame done");
  endtask
  task automatic t_test();
    cmd(1'b1);
    stall = 1;
    frame(SPDF_DAY, 0, 830, 1);
    frame(SPDF_NIGHT, 0, 171, 1);
    frame(SPDF_ENG1, 0, 830, 1);
    stall = 0;
    cmd(1'b0);
    $display("test frames done");
  endtask
  task automatic t_eng1();
    frame(SPDF_ENG1, 8, 830, 3);
    $display("engineering group one frame done");
  endtask
  task automatic t_eng2();
    frame(SPDF_ENG2, 846, 830, 2);
    $display("engineering frame done");
  endtask
  initial begin
    repeat (20) @(negedge MCLK);
    RSTN = 1;
    @(negedge MCLK);
    check("ready", IN_READY, 1'b1);
    t_day();
    t_night();
    t_test();
    t_eng2();
    t_eng1();
    finish_test();
  end
endmodule
bind spdf_formatter spdf_formatter_props u_props (.MCLK, .RSTN, .FRAME_START,
  .FRAME_KIND, .OUT_VALID, .OUT_DATA, .OUT_FIRST, .OUT_LAST, .OUT_READY,
  .PKT_START, .HDR_APID, .HDR_PKT_TYPE, .HDR_SRC_ZERO, .MSG_CTRL_RR,
  .TEST_ACTIVE, .BUSY);

// >>> verification/spdf_sink.sv
// link receiver model: takes field words, may stall, keeps every word
`timescale 1ns/100ps
module spdf_sink (
  input wire logic clk,
  input wire logic rstn,
  input wire logic valid,
  input wire logic [11:0] data,
  input wire logic first,
  input wire logic last,
  input wire logic stall,
  output logic ready,
  output logic [12:0] tot
);
  logic [13:0] mem [0:8191];
  logic [1:0] ph;
  // a stalling receiver takes one word in three, so the buffer fills
  assign ready = !stall || ph == 2'h0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph <= 2'h0;
      tot <= 13'h0000;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (valid && ready) begin
        mem[tot] <= {first, last, data};
        tot <= tot + 13'h0001;
      end
    end
  end
endmodule
